// [core/lbp_pkg.sv]
package lbp_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_ASYNC_TX = 8'h40;
  localparam logic [7:0] OFF_ASYNC_RX = 8'h44;
  localparam logic [7:0] OFF_ISO_SHARED = 8'h48;
  localparam logic [7:0] OFF_ISO_RX = 8'h4c;
  localparam logic [7:0] OFF_BUF_STAT = 8'h50;
  localparam logic [7:0] OFF_EVT_STAT = 8'h60;
  localparam logic [7:0] OFF_EVT_MASK = 8'h64;
  localparam logic [7:0] OFF_ISO_CTRL = 8'h68;
  // buffer status and control layout
  localparam logic [31:0] BUF_STAT_RESET = 32'h00000055;
  localparam int BIT_ATQ_EMPTY = 0;
  localparam int BIT_ATQ_FULL = 1;
  localparam int BIT_ARQ_EMPTY = 2;
  localparam int BIT_ISQ_EMPTY = 4;
  localparam int BIT_ISQ_FULL = 5;
  localparam int BIT_IRQ_EMPTY = 6;
  localparam int BIT_DMA_EN = 12;
  localparam int SEL_LO = 13;
  localparam int SEL_HI = 14;
  localparam int CNT_LO = 16;
  localparam int CNT_HI = 24;
  localparam int CNT_W = CNT_HI - CNT_LO + 1;
  // iso control register layout
  localparam int MODE_LO = 0;
  localparam int MODE_HI = 2;
  localparam int BIT_CLR_SHARED = 8;
  localparam int BIT_CLR_RX = 9;
  typedef logic [2:0] iso_mode_t;
  localparam iso_mode_t ISO_MODE_RESET = 3'h0;
  localparam iso_mode_t ISO_MODE_DUAL_RX = 3'h3;
  // routing tag from the receiver: which config register matched
  localparam logic [1:0] ROUTE_CFG2 = 2'h1;
  localparam logic [1:0] ROUTE_CFG3 = 2'h2;
  // dma request sources
  typedef enum logic [1:0] {
    SEL_ATQ_FULL = 2'h0,
    SEL_ATQ_EMPTY = 2'h1,
    SEL_ISQ = 2'h2,
    SEL_IRQ_EMPTY = 2'h3
  } dma_sel_t;
  // event bits
  localparam int EVT_W = 4;
  localparam int EVT_ARQ_STORED = 0;
  localparam int EVT_ISQ_STORED = 1;
  localparam int EVT_IRQ_STORED = 2;
  localparam int EVT_OVERFLOW = 3;
  // apb slave phases
  typedef enum logic [1:0] {
    PH_IDLE = 2'h1,
    PH_DONE = 2'h2
  } apb_phase_t;
endpackage

// [core/link_buffer_ports.sv]
// Overview of operation
// - reading the async receive port pops the next stored word
// - shared iso port takes writes into iso transmit queue unless mode is dual receive
// - in dual receive mode the shared iso port is read from its receive queue
// - in dual receive mode the shared port carries packets matched by config two
// - reading the iso receive port pops the next received iso word
// - in dual receive mode the iso receive port carries packets matched by config three
// - buffer status and control resets to all four empty flags set
// - bit 0 shows async transmit queue empty, reset one
// - bit 1 shows async transmit queue full, reset zero
// - bit 2 shows async receive queue empty, reset one
// - bits 4 and 5 show shared iso queue empty and full
// - bit 6 shows iso receive queue empty, reset one
// - dma request stays low unless enabled, then follows chosen condition
// - select field picks async full, async empty, shared iso, iso receive empty
// - count field reports quadlets in the iso queue chosen by select
`timescale 1ns/1ns
`default_nettype none
module link_buffer_ports
  import lbp_pkg::*;
#(
  parameter int DEPTH = 256
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // async transmit words toward the link
  output logic [31:0] atx_word,
  output logic atx_valid,
  input wire logic atx_take,
  // async receive words from the link
  input wire logic [31:0] arx_word,
  input wire logic arx_valid,
  // iso transmit words toward the link
  output logic [31:0] itx_word,
  output logic itx_valid,
  input wire logic itx_take,
  // iso receive words from the link, tagged by matching config
  input wire logic [31:0] irx_word,
  input wire logic irx_valid,
  input wire logic [1:0] irx_route,
  // system outputs
  output logic dma_request_out,
  output logic irq
);
  localparam int CW = $clog2(DEPTH + 1);

  queue_if #(.WIDTH(32), .CW(CW)) atq_if();
  queue_if #(.WIDTH(32), .CW(CW)) arq_if();
  queue_if #(.WIDTH(32), .CW(CW)) isq_if();
  queue_if #(.WIDTH(32), .CW(CW)) irq_if();

  word_queue #(.WIDTH(32), .DEPTH(DEPTH), .CW(CW)) u_atq (.pclk(pclk), .presetn(presetn), .q(atq_if.owner));
  word_queue #(.WIDTH(32), .DEPTH(DEPTH), .CW(CW)) u_arq (.pclk(pclk), .presetn(presetn), .q(arq_if.owner));
  word_queue #(.WIDTH(32), .DEPTH(DEPTH), .CW(CW)) u_isq (.pclk(pclk), .presetn(presetn), .q(isq_if.owner));
  word_queue #(.WIDTH(32), .DEPTH(DEPTH), .CW(CW)) u_irq (.pclk(pclk), .presetn(presetn), .q(irq_if.owner));

  apb_phase_t phase;
  iso_mode_t iso_operating_mode;
  logic dma_request_enable;
  dma_sel_t dma_request_source;
  logic [EVT_W-1:0] evt_status;
  logic [EVT_W-1:0] evt_mask;
  logic rd_armed;

  // apb decode: completion edge is psel, penable and pready together
  wire access_done = psel & penable & pready;
  wire wr_done = access_done & pwrite;
  wire rd_done = access_done & ~pwrite;
  wire hit_atx = (paddr == OFF_ASYNC_TX);
  wire hit_arx = (paddr == OFF_ASYNC_RX);
  wire hit_shared = (paddr == OFF_ISO_SHARED);
  wire hit_irx = (paddr == OFF_ISO_RX);
  wire hit_stat = (paddr == OFF_BUF_STAT);
  wire hit_evt = (paddr == OFF_EVT_STAT);
  wire hit_mask = (paddr == OFF_EVT_MASK);
  wire hit_ctrl = (paddr == OFF_ISO_CTRL);
  wire mapped = hit_atx | hit_arx | hit_shared | hit_irx | hit_stat | hit_evt | hit_mask | hit_ctrl;
  wire dual_rx = (iso_operating_mode == ISO_MODE_DUAL_RX);

  // tx output stages refill whenever empty or being taken; the iso stage refills only outside dual receive mode
  wire atx_load = ~atq_if.empty & (~atx_valid | atx_take);
  wire itx_load = ~dual_rx & ~isq_if.empty & (~itx_valid | itx_take);

  // iso receive routing
  wire irx_to_shared = dual_rx & irx_valid & (irx_route == ROUTE_CFG2);
  wire irx_to_rx = irx_valid & (~dual_rx | (irx_route == ROUTE_CFG3));

  // queue requests
  assign atq_if.push = wr_done & hit_atx;
  assign atq_if.push_data = pwdata;
  assign atq_if.pop = atx_load;
  assign atq_if.clear = 1'b0;
  assign arq_if.push = arx_valid;
  assign arq_if.push_data = arx_word;
  assign arq_if.pop = rd_done & hit_arx & rd_armed;
  assign arq_if.clear = 1'b0;
  assign isq_if.push = dual_rx ? irx_to_shared : (wr_done & hit_shared);
  assign isq_if.push_data = dual_rx ? irx_word : pwdata;
  assign isq_if.pop = dual_rx ? (rd_done & hit_shared & rd_armed) : itx_load;
  assign isq_if.clear = wr_done & hit_ctrl & pwdata[BIT_CLR_SHARED];
  assign irq_if.push = irx_to_rx;
  assign irq_if.push_data = irx_word;
  assign irq_if.pop = rd_done & hit_irx & rd_armed;
  assign irq_if.clear = wr_done & hit_ctrl & pwdata[BIT_CLR_RX];

  // status flags; a word parked in a tx stage still counts as held
  wire atq_empty_flag = atq_if.empty & ~atx_valid;
  wire atq_full_flag = atq_if.full;
  wire arq_empty_flag = arq_if.empty;
  wire isq_empty_flag = isq_if.empty & (dual_rx | ~itx_valid);
  wire isq_full_flag = isq_if.full;
  wire irq_empty_flag = irq_if.empty;

  // count of the iso queue picked by the select field
  wire [CW-1:0] sel_count = (dma_request_source == SEL_IRQ_EMPTY) ? irq_if.count :
                            (dma_request_source == SEL_ISQ) ? isq_if.count : '0;
  wire [CNT_W-1:0] count_field = CNT_W'(sel_count);

  // dma request condition by source
  wire isq_dma_cond = dual_rx ? isq_empty_flag : isq_full_flag;
  wire dma_cond = (dma_request_source == SEL_ATQ_FULL) ? atq_full_flag :
                  (dma_request_source == SEL_ATQ_EMPTY) ? atq_empty_flag :
                  (dma_request_source == SEL_ISQ) ? isq_dma_cond : irq_empty_flag;

  // buffer status and control word
  wire [31:0] buf_stat_word = {7'h00, count_field, 1'b0, dma_request_source, dma_request_enable, 5'h00,
                               irq_empty_flag, isq_full_flag, isq_empty_flag, 1'b0,
                               arq_empty_flag, atq_full_flag, atq_empty_flag};

  // read data selection; empty queues read as zero
  wire [31:0] arx_rd = arq_if.empty ? 32'h00000000 : arq_if.head;
  wire [31:0] shared_rd = (dual_rx & ~isq_if.empty) ? isq_if.head : 32'h00000000;
  wire [31:0] irx_rd = irq_if.empty ? 32'h00000000 : irq_if.head;
  wire [31:0] ctrl_rd = {29'h00000000, iso_operating_mode};
  wire [31:0] rd_mux = hit_arx ? arx_rd :
                       hit_shared ? shared_rd :
                       hit_irx ? irx_rd :
                       hit_stat ? buf_stat_word :
                       hit_evt ? {28'h0000000, evt_status} :
                       hit_mask ? {28'h0000000, evt_mask} :
                       hit_ctrl ? ctrl_rd : 32'h00000000;

  // apb slave: one wait state, data latched before the completion edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase <= PH_IDLE;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      case (phase)
        PH_IDLE: begin
          if (psel & penable) begin
            phase <= PH_DONE;
            pready <= 1'b1;
            pslverr <= ~mapped;
            prdata <= pwrite ? 32'h00000000 : rd_mux;
          end
        end
        PH_DONE: begin
          phase <= PH_IDLE;
          pready <= 1'b0;
          pslverr <= 1'b0;
        end
        default: begin
          phase <= PH_IDLE;
          pready <= 1'b0;
          pslverr <= 1'b0;
        end
      endcase
    end
  end

  // a pop is armed only when the word latched into prdata was real, so a
  // word landing during the wait state stays queued instead of being lost
  wire rd_word_ready = (hit_arx & ~arq_if.empty) | (hit_irx & ~irq_if.empty) |
                       (hit_shared & dual_rx & ~isq_if.empty);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_armed <= 1'b0;
    end else begin
      rd_armed <= (phase == PH_IDLE) & psel & penable & ~pwrite & rd_word_ready;
    end
  end

  // software-written control
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dma_request_enable <= 1'b0;
      dma_request_source <= SEL_ATQ_FULL;
      iso_operating_mode <= ISO_MODE_RESET;
      evt_mask <= '0;
    end else if (wr_done) begin
      if (hit_stat) begin
        dma_request_enable <= pwdata[BIT_DMA_EN];
        dma_request_source <= dma_sel_t'(pwdata[SEL_HI:SEL_LO]);
      end
      if (hit_ctrl) begin
        iso_operating_mode <= pwdata[MODE_HI:MODE_LO];
      end
      if (hit_mask) begin
        evt_mask <= pwdata[EVT_W-1:0];
      end
    end
  end

  // events; a new event beats a write-one clear in the same cycle
  wire [EVT_W-1:0] evt_clr = (wr_done & hit_evt) ? pwdata[EVT_W-1:0] : '0;
  wire ovf = (arx_valid & arq_if.full) | (irx_to_shared & isq_if.full) | (irx_to_rx & irq_if.full);
  wire [EVT_W-1:0] evt_set = {ovf, irx_to_rx & ~irq_if.full, irx_to_shared & ~isq_if.full,
                              arx_valid & ~arq_if.full};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_status <= '0;
      irq <= 1'b0;
    end else begin
      evt_status <= (evt_status & ~evt_clr) | evt_set;
      irq <= |(evt_status & evt_mask);
    end
  end

  // dma request follows the picked condition, registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dma_request_out <= 1'b0;
    end else begin
      dma_request_out <= dma_request_enable & dma_cond;
    end
  end

  // async transmit output stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      atx_valid <= 1'b0;
      atx_word <= 32'h00000000;
    end else if (atx_load) begin
      atx_valid <= 1'b1;
      atx_word <= atq_if.head;
    end else if (atx_take) begin
      atx_valid <= 1'b0;
    end
  end

  // iso transmit output stage, idle while the shared queue receives
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      itx_valid <= 1'b0;
      itx_word <= 32'h00000000;
    end else if (itx_load) begin
      itx_valid <= 1'b1;
      itx_word <= isq_if.head;
    end else if (itx_take | dual_rx) begin
      itx_valid <= 1'b0;
    end
  end

  // assertion helpers
  logic after_reset;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      after_reset <= 1'b0;
    end else begin
      after_reset <= 1'b1;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_arx_read;
    rd_done && hit_arx && !arq_if.empty && !arx_valid && rd_armed;
  endsequence
  sequence s_shared_host_write;
    wr_done && hit_shared && !dual_rx && !isq_if.full && !itx_load;
  endsequence
  sequence s_request_wait;
    psel && penable && !pready;
  endsequence
  sequence s_cfg3_arrival;
    irx_valid && dual_rx && irx_route == ROUTE_CFG3 && !irq_if.full && !(rd_done && hit_irx) && !irq_if.clear;
  endsequence

  AST_RESET_STATUS: assert property (!after_reset |-> buf_stat_word == BUF_STAT_RESET)
    else $error("status word wrong after reset");
  AST_ARX_POP: assert property (s_arx_read |=> arq_if.count == $past(arq_if.count) - CW'(1))
    else $error("async receive read did not pop one word");
  AST_SHARED_WRITE: assert property (s_shared_host_write |=> isq_if.count == $past(isq_if.count) + CW'(1))
    else $error("shared port write not stored");
  AST_SHARED_READ: assert property (rd_done && hit_shared && dual_rx && rd_armed |-> prdata == isq_if.head)
    else $error("shared port read data wrong");
  AST_ROUTE_CFG2: assert property (irx_valid && dual_rx && irx_route == ROUTE_CFG2 && !isq_if.full
                                   && !(rd_done && hit_shared) && !isq_if.clear
                                   |=> isq_if.count == $past(isq_if.count) + CW'(1))
    else $error("config two packet not routed to shared queue");
  AST_IRX_READ: assert property (rd_done && hit_irx && rd_armed |-> prdata == irq_if.head)
    else $error("iso receive read data wrong");
  AST_ROUTE_CFG3: assert property (irx_valid && dual_rx && irx_route == ROUTE_CFG2 |=> irq_if.count <= $past(irq_if.count))
    else $error("config two packet leaked into iso receive queue");
  AST_DMA_OFF: assert property (!dma_request_enable ##1 !dma_request_enable |-> !dma_request_out)
    else $error("dma request active while disabled");
  AST_DMA_ATQ_EMPTY: assert property (dma_request_enable && dma_request_source == SEL_ATQ_EMPTY
                                      && atq_empty_flag |=> dma_request_out)
    else $error("dma request missed async transmit empty");
  AST_COUNT_FIELD: assert property (dma_request_source == SEL_ATQ_FULL |-> buf_stat_word[CNT_HI:CNT_LO] == '0)
    else $error("count field nonzero for async select");
  AST_IRQ_LEVEL: assert property (|(evt_status & evt_mask) |=> irq)
    else $error("interrupt not raised for unmasked event");
  AST_ONE_WAIT: assert property (s_request_wait |=> pready ##1 !pready)
    else $error("apb answer not after one wait state");
  AST_EMPTY_READ_ZERO: assert property (rd_done && hit_arx && !rd_armed |-> prdata == 32'h00000000)
    else $error("empty async receive read returned data");
  AST_DUAL_WRITE_IGNORED: assert property (wr_done && hit_shared && dual_rx && !irx_to_shared
                                           |=> isq_if.count == $past(isq_if.count))
    else $error("shared port write stored in dual receive mode");
  AST_ROUTE_CFG3_STORE: assert property (s_cfg3_arrival |=> irq_if.count == $past(irq_if.count) + CW'(1))
    else $error("config three packet not routed to iso receive queue");
  AST_ATQ_FULL_FLAG: assert property (atq_if.count == CW'(DEPTH) |-> buf_stat_word[BIT_ATQ_FULL])
    else $error("async transmit full flag missing");
  AST_ARQ_EMPTY_FLAG: assert property (arq_if.count != '0 |-> !buf_stat_word[BIT_ARQ_EMPTY])
    else $error("async receive empty flag set while holding words");
  AST_SHARED_FLAGS: assert property (dual_rx && isq_if.count == CW'(DEPTH) |-> buf_stat_word[BIT_ISQ_FULL]
                                     && !buf_stat_word[BIT_ISQ_EMPTY])
    else $error("shared queue flags wrong when full");
  AST_DMA_IRQ_EMPTY: assert property (dma_request_enable && dma_request_source == SEL_IRQ_EMPTY && irq_if.empty
                                      |=> dma_request_out)
    else $error("dma request missed iso receive empty");
  AST_COUNT_IRX: assert property (dma_request_source == SEL_IRQ_EMPTY
                                  |-> buf_stat_word[CNT_HI:CNT_LO] == CNT_W'(irq_if.count))
    else $error("count field does not show iso receive count");
endmodule
`default_nettype wire

// [core/queue_if.sv]
`timescale 1ns/1ns
`default_nettype none
interface queue_if #(parameter int WIDTH = 32, parameter int CW = 9);
  logic push;
  logic pop;
  logic clear;
  logic [WIDTH-1:0] push_data;
  logic [WIDTH-1:0] head;
  logic [CW-1:0] count;
  logic empty;
  logic full;
  modport owner(input push, pop, clear, push_data, output head, count, empty, full);
  modport user(output push, pop, clear, push_data, input head, count, empty, full);
endinterface
`default_nettype wire

// [core/word_queue.sv]
`timescale 1ns/1ns
`default_nettype none
module word_queue #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 256,
  parameter int CW = 9
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // queue access
  queue_if.owner q
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [CW-1:0] count;
  wire do_push = q.push & ~q.full;
  wire do_pop = q.pop & ~q.empty;

  // storage has no reset, contents are only valid behind the pointers
  always_ff @(posedge pclk) begin
    if (do_push) begin
      mem[wr_ptr] <= q.push_data;
    end
  end

  // pointers wrap naturally: depth must be a power of two
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else if (q.clear) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      wr_ptr <= wr_ptr + AW'(do_push);
      rd_ptr <= rd_ptr + AW'(do_pop);
      count <= count + CW'(do_push) - CW'(do_pop);
    end
  end

  // flags follow the count from the edge after each access
  assign q.head = mem[rd_ptr];
  assign q.count = count;
  assign q.empty = (count == '0);
  assign q.full = (count == CW'(DEPTH));
endmodule
`default_nettype wire

// [tb/link_model.sv]
`timescale 1ns/1ns
`default_nettype none
module link_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // transmit words from the block
  input wire logic [31:0] atx_word,
  input wire logic atx_valid,
  output logic atx_take,
  input wire logic [31:0] itx_word,
  input wire logic itx_valid,
  output logic itx_take,
  // receive words into the block
  output logic [31:0] arx_word,
  output logic arx_valid,
  output logic [31:0] irx_word,
  output logic irx_valid,
  output logic [1:0] irx_route
);
  logic take_en = 1'b0;
  logic [31:0] atx_got[$];
  logic [31:0] itx_got[$];

  initial begin
    atx_take = 1'b0;
    itx_take = 1'b0;
    arx_word = 32'h00000000;
    arx_valid = 1'b0;
    irx_word = 32'h00000000;
    irx_valid = 1'b0;
    irx_route = 2'h0;
  end

  // link takes one word per cycle, stalls while take_en is low
  always @(posedge pclk) begin
    atx_take <= take_en;
    itx_take <= take_en;
    if (atx_take && atx_valid && presetn) atx_got.push_back(atx_word);
    if (itx_take && itx_valid && presetn) itx_got.push_back(itx_word);
  end

  // back-to-back words w, w+1, ...; lines flip after release so stale data never looks valid
  task automatic send(input logic iso, input logic [1:0] route, input logic [31:0] w, input int n);
    for (int i = 0; i < n; i++) begin
      if (iso) begin
        irx_word <= w + i;
        irx_route <= route;
        irx_valid <= 1'b1;
      end else begin
        arx_word <= w + i;
        arx_valid <= 1'b1;
      end
      @(posedge pclk);
    end
    arx_valid <= 1'b0;
    irx_valid <= 1'b0;
    arx_word <= ~arx_word;
    irx_word <= ~irx_word;
    irx_route <= ~irx_route;
  endtask
endmodule
`default_nettype wire

// [tb/testbench.sv]
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import lbp_pkg::*;
  localparam int DEPTH = 8;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [31:0] atx_word, arx_word, itx_word, irx_word;
  logic atx_valid, atx_take, arx_valid, itx_valid, itx_take, irx_valid, dma_request_out, irq;
  logic [1:0] irx_route;
  logic [31:0] exp_q[$];
  int mismatches = 0;
  int n_compared = 0;

  link_buffer_ports #(.DEPTH(DEPTH)) link_buffer_ports_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .atx_word(atx_word), .atx_valid(atx_valid), .atx_take(atx_take), .arx_word(arx_word),
    .arx_valid(arx_valid), .itx_word(itx_word), .itx_valid(itx_valid), .itx_take(itx_take),
    .irx_word(irx_word), .irx_valid(irx_valid), .irx_route(irx_route), .dma_request_out(dma_request_out),
    .irq(irq));
  link_model link_model_inst (.pclk(pclk), .presetn(presetn), .atx_word(atx_word), .atx_valid(atx_valid),
    .atx_take(atx_take), .itx_word(itx_word), .itx_valid(itx_valid), .itx_take(itx_take),
    .arx_word(arx_word), .arx_valid(arx_valid), .irx_word(irx_word), .irx_valid(irx_valid),
    .irx_route(irx_route));

  // 10 MHz clock
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  task automatic end_of_test();
    $display("counts: %0d compared, %0d mismatches", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // one apb transfer, whole 32-bit word; bounded wait for pready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    e = pslverr;
    if (n >= 20) begin
      mismatches++;
      end_of_test();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(q, exp);
  endtask

  // registered outputs lag their cause by a cycle
  task automatic dma_is(input logic v);
    repeat (2) @(posedge pclk);
    chk({31'h0, dma_request_out}, {31'h0, v});
  endtask

  initial begin
    #3000000;
    mismatches++;
    end_of_test();
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc(OFF_BUF_STAT, BUF_STAT_RESET);
    rdc(OFF_ASYNC_RX, 32'h0);
    dma_is(1'b0);
    apb(1'b0, 8'h7c, 32'h0);
    chk({31'h0, e}, 32'h1);
    $display("test reset done");
    // async receive: order, flag, event, irq mask and clear
    link_model_inst.send(1'b0, 2'h0, 32'ha0000001, 3);
    rdc(OFF_BUF_STAT, 32'h51);
    for (int i = 0; i < 3; i++) rdc(OFF_ASYNC_RX, 32'ha0000001 + i);
    rdc(OFF_BUF_STAT, 32'h55);
    rdc(OFF_EVT_STAT, 32'h1);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, OFF_EVT_MASK, 32'h1);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, OFF_EVT_STAT, 32'h1);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    rdc(OFF_EVT_STAT, 32'h0);
    $display("test async rx done");
    // async transmit filled with the link stalled
    for (int i = 0; i <= DEPTH; i++) apb(1'b1, OFF_ASYNC_TX, 32'hb0 + i);
    rdc(OFF_BUF_STAT, 32'h56);
    apb(1'b1, OFF_BUF_STAT, 32'h1000);
    dma_is(1'b1);
    apb(1'b1, OFF_BUF_STAT, 32'h0);
    dma_is(1'b0);
    link_model_inst.take_en <= 1'b1;
    repeat (3 * DEPTH) @(posedge pclk);
    chk(32'(link_model_inst.atx_got.size()), 32'(DEPTH + 1));
    for (int i = 0; i <= DEPTH; i++) chk(link_model_inst.atx_got[i], 32'hb0 + i);
    rdc(OFF_BUF_STAT, 32'h55);
    apb(1'b1, OFF_BUF_STAT, 32'h3000);
    dma_is(1'b1);
    $display("test async tx done");
    // shared port writes in modes 0 to 5; dual receive ignores them
    for (int m = 0; m < 6; m++) begin
      apb(1'b1, OFF_ISO_CTRL, 32'(m));
      apb(1'b1, OFF_ISO_SHARED, 32'hc0 + m);
      repeat (4) @(posedge pclk);
      if (m != 3) exp_q.push_back(32'hc0 + m);
    end
    chk(32'(link_model_inst.itx_got.size()), 32'(exp_q.size()));
    foreach (exp_q[i]) chk(link_model_inst.itx_got[i], exp_q[i]);
    $display("test iso tx done");
    // dual receive routing by matching config, count and request
    apb(1'b1, OFF_ISO_CTRL, 32'(ISO_MODE_DUAL_RX));
    link_model_inst.send(1'b1, ROUTE_CFG2, 32'hd0, DEPTH + 1);
    link_model_inst.send(1'b1, ROUTE_CFG3, 32'he0, 2);
    link_model_inst.send(1'b1, 2'h0, 32'hf0, 1);
    rdc(OFF_EVT_STAT, 32'he);
    apb(1'b1, OFF_BUF_STAT, 32'h4000);
    apb(1'b0, OFF_BUF_STAT, 32'h0);
    chk(q & 32'h01ff0070, {7'h0, 9'(DEPTH), 16'h0020});
    apb(1'b1, OFF_BUF_STAT, 32'h5000);
    dma_is(1'b0);
    for (int i = 0; i < DEPTH; i++) rdc(OFF_ISO_SHARED, 32'hd0 + i);
    dma_is(1'b1);
    apb(1'b1, OFF_BUF_STAT, 32'h6000);
    apb(1'b0, OFF_BUF_STAT, 32'h0);
    chk(q & 32'h01ff0070, {7'h0, 9'd2, 16'h0010});
    apb(1'b1, OFF_BUF_STAT, 32'h7000);
    dma_is(1'b0);
    rdc(OFF_ISO_RX, 32'he0);
    rdc(OFF_ISO_RX, 32'he1);
    rdc(OFF_ISO_RX, 32'h0);
    dma_is(1'b1);
    $display("test iso rx dual done");
    // normal mode sends every received iso word to the iso receive port
    apb(1'b1, OFF_ISO_CTRL, 32'h0);
    link_model_inst.send(1'b1, ROUTE_CFG2, 32'h90, 1);
    rdc(OFF_ISO_SHARED, 32'h0);
    rdc(OFF_ISO_RX, 32'h90);
    link_model_inst.send(1'b1, ROUTE_CFG2, 32'h91, 1);
    apb(1'b1, OFF_ISO_CTRL, 32'h200);
    rdc(OFF_ISO_RX, 32'h0);
    $display("test iso rx normal done");
    // reset in mid-run brings control and status back to reset values
    apb(1'b1, OFF_ISO_CTRL, 32'(ISO_MODE_DUAL_RX));
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc(OFF_BUF_STAT, BUF_STAT_RESET);
    rdc(OFF_ISO_CTRL, 32'h0);
    $display("test mid reset done");
    end_of_test();
  end
endmodule
`default_nettype wire
